// *** usb_ep_select.sv ***
// Endpoint-zero token status, endpoint select and per-endpoint control access
`timescale 1ns/1ps
module usb_ep_select
	import usb_ep_sel_pkg::*;
(
	input  wire logic       clk_sys,
	input  wire logic       rst_b,
	input  wire logic [7:0] sfr_addr,
	input  wire logic       sfr_wr,
	input  wire logic       sfr_rd,
	input  wire logic [7:0] sfr_wdata,
	output logic      [7:0] sfr_rdata,
	input  wire logic       usb_function_enable,
	input  wire logic       fifo_visible,
	input  wire logic       tok_valid,
	input  wire logic [1:0] tok_type,
	input  wire logic [2:0] tok_ep,
	input  wire logic       data_valid,
	input  wire logic       data_toggle,
	input  wire logic       sie_ctrl_we,
	input  wire logic [3:0] sie_ctrl_slot,
	input  wire logic [3:0] sie_ctrl_wdata,
	output logic            fifo_window_en,
	output logic      [2:0] fifo_ep,
	output logic            fifo_dir_out,
	output logic            sie_active
);
	// ------------------------------------------------------------
	// Reset release
	// ------------------------------------------------------------
	logic rst_s1_q;
	logic rst_n_q;

	// Two-stage release of the asynchronous reset
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			rst_s1_q <= 1'b0;
			rst_n_q  <= 1'b0;
		end else begin
			rst_s1_q <= 1'b1;
			rst_n_q  <= rst_s1_q;
		end
	end

	// ------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------
	// Slot index for an endpoint/direction; invalid endpoints map past the end
	function automatic logic [SLOT_W-1:0] slot_of(input logic [2:0] ep, input logic dir);
		slot_of = (32'(ep) < NUM_EP) ? SLOT_W'({ep, dir}) : SLOT_W'(NUM_SLOTS);
	endfunction

	// ------------------------------------------------------------
	// Registers
	// ------------------------------------------------------------
	logic       rx_toggle_q, rx_toggle_d;
	logic       setup_q, setup_d;
	logic       in_q,    in_d;
	logic       out_q,   out_d;
	logic       dir_q,   dir_d;
	logic [2:0] ep_q,    ep_d;
	logic       en_prev_q;
	logic [7:0] rdata_d;
	logic       win_d;
	logic       ep0_tok;
	logic       en_rise;
	logic       sel_valid;
	logic [3:0] ctrl_rdata;
	logic       ctrl_we;
	logic [SLOT_W-1:0] ctrl_waddr;
	logic [CTRL_W-1:0] ctrl_wdata;

	assign sel_valid = (32'(ep_q) < NUM_EP);
	assign ep0_tok   = tok_valid && usb_function_enable && (tok_ep == 3'h0);
	assign en_rise   = usb_function_enable && !en_prev_q;

	// Status and select next values
	always_comb begin
		rx_toggle_d = rx_toggle_q;
		setup_d = setup_q;
		in_d    = in_q;
		out_d   = out_q;
		dir_d   = dir_q;
		ep_d    = ep_q;
		if (sfr_wr && sfr_addr == ADDR_EP0_STATUS) begin
			setup_d = sfr_wdata[BIT_SETUP];
		end
		if (sfr_wr && sfr_addr == ADDR_EP_SELECT) begin
			dir_d = sfr_wdata[BIT_DIR];
			ep_d  = sfr_wdata[EP_FIELD_MSB:0];
		end
		if (en_rise) begin
			rx_toggle_d = 1'b0;
			in_d   = 1'b0;
			out_d  = 1'b0;
		end
		if (data_valid && usb_function_enable) begin
			rx_toggle_d = data_toggle;
		end
		if (ep0_tok) begin
			unique case (tok_type)
				TOKEN_SETUP: begin
					setup_d = 1'b1;
					in_d    = 1'b0;
					out_d   = 1'b0;
				end
				TOKEN_IN: begin
					in_d  = 1'b1;
					out_d = 1'b0;
				end
				TOKEN_OUT: begin
					out_d = 1'b1;
					in_d  = 1'b0;
				end
				default: begin
				end
			endcase
		end
	end

	// Status and select storage
	always_ff @(posedge clk_sys or negedge rst_n_q) begin
		if (!rst_n_q) begin
			rx_toggle_q <= RST_EP0_STATUS[BIT_RX_TOGGLE];
			setup_q   <= RST_EP0_STATUS[BIT_SETUP];
			in_q      <= RST_EP0_STATUS[BIT_IN];
			out_q     <= RST_EP0_STATUS[BIT_OUT];
			dir_q     <= RST_EP_SELECT[BIT_DIR];
			ep_q      <= RST_EP_SELECT[EP_FIELD_MSB:0];
			en_prev_q <= 1'b0;
		end else begin
			rx_toggle_q <= rx_toggle_d;
			setup_q   <= setup_d;
			in_q      <= in_d;
			out_q     <= out_d;
			dir_q     <= dir_d;
			ep_q      <= ep_d;
			en_prev_q <= usb_function_enable;
		end
	end

	// ------------------------------------------------------------
	// Per-endpoint control store
	// ------------------------------------------------------------
	// CPU write wins over any engine update in the same cycle, even one to another slot; that engine update is lost
	always_comb begin
		ctrl_we    = 1'b0;
		ctrl_waddr = sie_ctrl_slot;
		ctrl_wdata = sie_ctrl_wdata;
		if (sfr_wr && sfr_addr == ADDR_EP_CONTROL && sel_valid) begin
			ctrl_we    = 1'b1;
			ctrl_waddr = slot_of(ep_q, dir_q);
			ctrl_wdata = sfr_wdata[CTRL_W-1:0];
		end else if (sie_ctrl_we) begin
			ctrl_we = 1'b1;
		end
	end

	ep_ctrl_mem #(
		.DEPTH (NUM_SLOTS),
		.WIDTH (CTRL_W),
		.AW    (SLOT_W),
		.INIT  (RST_EP_CONTROL)
	) u_ctrl (
		.clk   (clk_sys),
		.rst_n (rst_n_q),
		.we    (ctrl_we),
		.waddr (ctrl_waddr),
		.wdata (ctrl_wdata),
		.raddr (slot_of(ep_d, dir_d)),
		.rdata (ctrl_rdata)
	);

	// ------------------------------------------------------------
	// Read mux and outputs
	// ------------------------------------------------------------
	// Registered read data; reserved bits read zero
	always_comb begin
		rdata_d = 8'h00;
		if (sfr_rd) begin
			unique case (sfr_addr)
				ADDR_EP0_STATUS: rdata_d = {4'h0, rx_toggle_q, setup_q, in_q, out_q};
				ADDR_EP_SELECT:  rdata_d = {dir_q, 4'h0, ep_q};
				ADDR_EP_CONTROL: rdata_d = sel_valid ? {4'h0, ctrl_rdata} : 8'h00;
				default:         rdata_d = 8'h00;
			endcase
		end
		win_d = fifo_visible && (32'(ep_d) < NUM_EP);
	end

	always_ff @(posedge clk_sys or negedge rst_n_q) begin
		if (!rst_n_q) begin
			sfr_rdata      <= 8'h00;
			fifo_window_en <= 1'b0;
			fifo_ep        <= 3'h0;
			fifo_dir_out   <= 1'b0;
			sie_active     <= 1'b0;
		end else begin
			sfr_rdata      <= rdata_d;
			fifo_window_en <= win_d;
			fifo_ep        <= ep_d;
			fifo_dir_out   <= dir_d;
			sie_active     <= usb_function_enable;
		end
	end

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	a_setup_sets: assert property (@(posedge clk_sys) disable iff (!rst_n_q)
		(ep0_tok && tok_type == TOKEN_SETUP) |=> setup_q)
		else $error("setup bit not set");
	a_setup_holds: assert property (@(posedge clk_sys) disable iff (!rst_n_q)
		(setup_q && !(sfr_wr && sfr_addr == ADDR_EP0_STATUS)) |=> setup_q)
		else $error("setup bit dropped");
	a_in_token: assert property (@(posedge clk_sys) disable iff (!rst_n_q)
		(ep0_tok && tok_type == TOKEN_IN) |=> (in_q && !out_q))
		else $error("in bit wrong");
	a_out_token: assert property (@(posedge clk_sys) disable iff (!rst_n_q)
		(ep0_tok && tok_type == TOKEN_OUT) |=> (out_q && !in_q))
		else $error("out bit wrong");
	a_toggle_seen: assert property (@(posedge clk_sys) disable iff (!rst_n_q)
		(data_valid && usb_function_enable) |=> (rx_toggle_q == $past(data_toggle)))
		else $error("toggle bit wrong");
	a_reenable_clear: assert property (@(posedge clk_sys) disable iff (!rst_n_q)
		(en_rise && !ep0_tok && !data_valid) |=> (!rx_toggle_q && !in_q && !out_q))
		else $error("re-enable did not clear");
	a_disabled_ignore: assert property (@(posedge clk_sys) disable iff (!rst_n_q)
		(!usb_function_enable && !en_rise && !(sfr_wr && sfr_addr == ADDR_EP0_STATUS))
		|=> $stable({setup_q, in_q, out_q}))
		else $error("token taken while disabled");
	a_window_gate: assert property (@(posedge clk_sys) disable iff (!rst_n_q)
		fifo_window_en |-> ($past(fifo_visible) && fifo_ep < 3'h5))
		else $error("window open when hidden");
	a_status_resvd: assert property (@(posedge clk_sys) disable iff (!rst_n_q)
		($past(sfr_rd) && $past(sfr_addr) == ADDR_EP0_STATUS) |-> (sfr_rdata[7:4] == 4'h0))
		else $error("reserved bits nonzero");
endmodule

// *** usb_ep_sel_pkg.sv ***
// Package: SFR addresses, field positions and reset values for endpoint status/select
package usb_ep_sel_pkg;
	localparam logic [7:0] ADDR_EP0_STATUS  = 8'hED;
	localparam logic [7:0] ADDR_EP_SELECT   = 8'hEF;
	localparam logic [7:0] ADDR_EP_CONTROL  = 8'hF1;
	localparam logic [7:0] RST_EP0_STATUS   = 8'h00;
	localparam logic [7:0] RST_EP_SELECT    = 8'h00;
	localparam logic [3:0] RST_EP_CONTROL   = 4'h8;
	localparam int         BIT_RX_TOGGLE    = 3;
	localparam int         BIT_SETUP        = 2;
	localparam int         BIT_IN           = 1;
	localparam int         BIT_OUT          = 0;
	localparam int         BIT_DIR          = 7;
	localparam int         EP_FIELD_MSB     = 2;
	localparam int         NUM_EP           = 5;
	localparam int         NUM_SLOTS        = 10;
	localparam int         SLOT_W           = 4;
	localparam int         CTRL_W           = 4;
	localparam logic [1:0] TOKEN_OUT        = 2'h0;
	localparam logic [1:0] TOKEN_IN         = 2'h1;
	localparam logic [1:0] TOKEN_SETUP      = 2'h3;
endpackage

// *** ep_ctrl_mem.sv ***
// Small register memory holding one control nibble per endpoint and direction
`timescale 1ns/1ps
module ep_ctrl_mem #(
	parameter int DEPTH = 10,
	parameter int WIDTH = 4,
	parameter int AW    = 4,
	parameter logic [WIDTH-1:0] INIT = '0
) (
	input  wire logic             clk,
	input  wire logic             rst_n,
	input  wire logic             we,
	input  wire logic [AW-1:0]    waddr,
	input  wire logic [WIDTH-1:0] wdata,
	input  wire logic [AW-1:0]    raddr,
	output logic      [WIDTH-1:0] rdata
);
	logic [WIDTH-1:0] mem_q [DEPTH];
	logic [WIDTH-1:0] rdata_d;

	// Read path, registered; a write to the read slot passes through so the next read is fresh
	always_comb begin
		if (32'(raddr) >= DEPTH) begin
			rdata_d = '0;
		end else if (we && (waddr == raddr)) begin
			rdata_d = wdata;
		end else begin
			rdata_d = mem_q[raddr];
		end
	end

	// Storage and read register
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			for (int i = 0; i < DEPTH; i++) begin
				mem_q[i] <= INIT;
			end
			rdata <= '0;
		end else begin
			if (we && (32'(waddr) < DEPTH)) begin
				mem_q[waddr] <= wdata;
			end
			rdata <= rdata_d;
		end
	end
endmodule

// *** usb_host_model.sv ***
// Host-side source of tokens and data packets for the endpoint block
`timescale 1ns/1ps
module usb_host_model (
	input  wire logic       clk,
	output logic            tok_valid,
	output logic      [1:0] tok_type,
	output logic      [2:0] tok_ep,
	output logic            data_valid,
	output logic            data_toggle
);
	// Idle levels at time zero
	initial begin
		tok_valid = 1'b0;
		tok_type = 2'h2;
		tok_ep = 3'h7;
		data_valid = 1'b0;
		data_toggle = 1'b0;
	end

	// One token; idle fields then show the inverse, never the held value
	task automatic token(input logic [1:0] t, input logic [2:0] e);
		@(posedge clk);
		tok_valid <= 1'b1;
		tok_type <= t;
		tok_ep <= e;
		@(posedge clk);
		tok_valid <= 1'b0;
		tok_type <= ~t;
		tok_ep <= ~e;
	endtask

	// One data packet carrying its toggle
	task automatic packet(input logic tg);
		@(posedge clk);
		data_valid <= 1'b1;
		data_toggle <= tg;
		@(posedge clk);
		data_valid <= 1'b0;
		data_toggle <= ~tg;
	endtask
endmodule

// *** testbench.sv ***
// Self-checking bench for endpoint status, select and control registers
`timescale 1ns/1ps
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin fail_count++; $display("unexpected at %0t: got %h want %h", $time, a, b); end end
module testbench
	import usb_ep_sel_pkg::*;
;
	logic       clk_sys = 1'b0;
	logic       rst_b = 1'b0;
	logic [7:0] sfr_addr = 8'h00;
	logic       sfr_wr = 1'b0;
	logic       sfr_rd = 1'b0;
	logic [7:0] sfr_wdata = 8'h00;
	logic [7:0] sfr_rdata;
	logic       usb_function_enable = 1'b0;
	logic       fifo_visible = 1'b0;
	logic       tok_valid, data_valid, data_toggle;
	logic [1:0] tok_type;
	logic [2:0] tok_ep;
	logic       sie_ctrl_we = 1'b0;
	logic [3:0] sie_ctrl_slot = 4'h0;
	logic [3:0] sie_ctrl_wdata = 4'h0;
	logic       fifo_window_en, fifo_dir_out, sie_active, rd_pend = 1'b0;
	logic [2:0] fifo_ep;
	logic [7:0] exp_q[$];
	logic [3:0] ctl[16];
	logic [3:0] st;
	logic [7:0] sel, e;
	logic [3:0] nib, slot;
	int         fail_count = 0;
	int         total_checks = 0;

	always #2.5 clk_sys = ~clk_sys;

	usb_ep_select dut (.clk_sys(clk_sys), .rst_b(rst_b), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd),
		.sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata), .usb_function_enable(usb_function_enable),
		.fifo_visible(fifo_visible), .tok_valid(tok_valid), .tok_type(tok_type), .tok_ep(tok_ep),
		.data_valid(data_valid), .data_toggle(data_toggle), .sie_ctrl_we(sie_ctrl_we),
		.sie_ctrl_slot(sie_ctrl_slot), .sie_ctrl_wdata(sie_ctrl_wdata), .fifo_window_en(fifo_window_en),
		.fifo_ep(fifo_ep), .fifo_dir_out(fifo_dir_out), .sie_active(sie_active));
	usb_host_model host (.clk(clk_sys), .tok_valid(tok_valid), .tok_type(tok_type), .tok_ep(tok_ep),
		.data_valid(data_valid), .data_toggle(data_toggle));

	// Read data watcher: oldest note against the answer of each read
	always @(posedge clk_sys) rd_pend <= sfr_rd;
	always @(negedge clk_sys) begin
		if (rd_pend) begin
			e = exp_q.pop_front();
			`CHK(sfr_rdata, e)
		end
	end

	// Register bus cycles
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_sys);
		sfr_wr <= 1'b1;
		sfr_addr <= a;
		sfr_wdata <= d;
		@(posedge clk_sys);
		sfr_wr <= 1'b0;
		sfr_wdata <= ~d;
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] x);
		@(posedge clk_sys);
		sfr_rd <= 1'b1;
		sfr_addr <= a;
		exp_q.push_back(x);
		@(posedge clk_sys);
		sfr_rd <= 1'b0;
	endtask

	// Token or packet from the host, then status read against the model
	task automatic tk(input logic [1:0] t, input logic [2:0] ep);
		host.token(t, ep);
		if (usb_function_enable && ep == 3'h0) begin
			st[BIT_SETUP] = st[BIT_SETUP] | (t == TOKEN_SETUP);
			st[BIT_IN] = (t == TOKEN_IN);
			st[BIT_OUT] = (t == TOKEN_OUT);
		end
		rd(ADDR_EP0_STATUS, {4'h0, st});
	endtask
	task automatic pk(input logic tg);
		host.packet(tg);
		if (usb_function_enable)
			st[BIT_RX_TOGGLE] = tg;
		rd(ADDR_EP0_STATUS, {4'h0, st});
	endtask

	task automatic summarize;
		$display("checks %0d mismatches %0d", total_checks, fail_count);
		if (fail_count == 0 && total_checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	// Watchdog
	initial begin
		repeat (20000) @(posedge clk_sys);
		fail_count++;
		summarize();
	end

	// Main sequence
	initial begin
		void'($urandom(32'h6e75b736));
		foreach (ctl[i]) ctl[i] = RST_EP_CONTROL;
		st = 4'h0;
		repeat (3) @(posedge clk_sys);
		rst_b <= 1'b1;
		repeat (3) @(posedge clk_sys);
		rd(ADDR_EP0_STATUS, RST_EP0_STATUS);
		rd(ADDR_EP_SELECT, RST_EP_SELECT);
		rd(ADDR_EP_CONTROL, {4'h0, RST_EP_CONTROL});
		rd(8'h00, 8'h00);
		usb_function_enable <= 1'b1;
		tk(TOKEN_SETUP, 3'h0);
		tk(TOKEN_IN, 3'h0);
		tk(TOKEN_OUT, 3'h0);
		tk(TOKEN_IN, 3'h1);
		pk(1'b1);
		tk(TOKEN_IN, 3'h0);
		pk(1'b0);
		pk(1'b1);
		wr(ADDR_EP0_STATUS, 8'hF0);
		st[BIT_SETUP] = 1'b0;
		rd(ADDR_EP0_STATUS, {4'h0, st});
		wr(ADDR_EP0_STATUS, 8'h0F);
		st[BIT_SETUP] = 1'b1;
		rd(ADDR_EP0_STATUS, {4'h0, st});
		usb_function_enable <= 1'b0;
		tk(TOKEN_OUT, 3'h0);
		pk(1'b0);
		`CHK(sie_active, 1'b0)
		usb_function_enable <= 1'b1;
		st = st & 4'h4;
		rd(ADDR_EP0_STATUS, {4'h0, st});
		`CHK(sie_active, 1'b1)
		// Every select value, reserved bits random, engine updates interleaved
		for (int i = 0; i < 24; i++) begin
			sel = 8'($urandom);
			if (i < 16)
				sel = {i[0], sel[6:3], i[3:1]};
			nib = 4'($urandom);
			@(posedge clk_sys);
			fifo_visible <= sel[5];
			wr(ADDR_EP_SELECT, sel);
			wr(ADDR_EP_CONTROL, {4'($urandom), nib});
			if (sel[2:0] < 3'h5)
				ctl[{sel[2:0], sel[7]}] = nib;
			slot = 4'($urandom_range(9));
			@(posedge clk_sys);
			sie_ctrl_we <= 1'b1;
			sie_ctrl_slot <= slot;
			sie_ctrl_wdata <= ~nib;
			@(posedge clk_sys);
			sie_ctrl_we <= 1'b0;
			ctl[slot] = ~nib;
			rd(ADDR_EP_SELECT, {sel[7], 4'h0, sel[2:0]});
			rd(ADDR_EP_CONTROL, sel[2:0] < 3'h5 ? {4'h0, ctl[{sel[2:0], sel[7]}]} : 8'h00);
			@(negedge clk_sys);
			`CHK(fifo_ep, sel[2:0])
			`CHK(fifo_dir_out, sel[7])
			`CHK(fifo_window_en, sel[5] && sel[2:0] < 3'h5)
		end
		// Control write then read on the very next edge
		wr(ADDR_EP_SELECT, 8'h82);
		@(posedge clk_sys);
		sfr_wr <= 1'b1;
		sfr_addr <= ADDR_EP_CONTROL;
		sfr_wdata <= 8'h05;
		@(posedge clk_sys);
		sfr_wr <= 1'b0;
		sfr_rd <= 1'b1;
		exp_q.push_back(8'h05);
		@(posedge clk_sys);
		sfr_rd <= 1'b0;
		repeat (3) @(posedge clk_sys);
		summarize();
	end
endmodule
